// [ebu_cfg.svh]
`ifndef EBU_CFG_SVH
`define EBU_CFG_SVH
// Bus configuration word layout
`define EBU_CFG_W      11
`define EBU_F_WAIT_LO  0
`define EBU_F_WAIT_HI  3
`define EBU_F_TRIST    4
`define EBU_F_ALE_EXT  5
`define EBU_F_RW_DLY   6
`define EBU_F_RDY_EN   7
`define EBU_F_MUX      8
`define EBU_F_BUS16    9
`define EBU_F_WIN_EN   10
// Window address select layout: base is A23..A12, size code is log2 of 4 KB units
`define EBU_SEL_SIZE_HI 3
`define EBU_SEL_BASE_LO 4
`define EBU_SEL_BASE_HI 15
`define EBU_WIN_LSB     12
// Address space codes
`define EBU_SPACE_64K  2'h0
`define EBU_SPACE_256K 2'h1
`define EBU_SPACE_1M   2'h2
`define EBU_SPACE_16M  2'h3
// Segment line masks per address space
`define EBU_SEG_64K    8'h00
`define EBU_SEG_256K   8'h03
`define EBU_SEG_1M     8'h0f
`define EBU_SEG_16M    8'hff
// Chip select index of the default region
`define EBU_CS_DEFAULT 0
`endif

// [ebu_pkg.sv]
`include "ebu_cfg.svh"
package ebu_pkg;
	typedef enum {ST_IDLE, ST_ALE, ST_RWD, ST_WAIT, ST_TRIST, ST_END, ST_HOLD} ebu_state_t;

	typedef struct packed {
		ebu_state_t            st;
		logic [3:0]            cnt;
		logic [23:0]           addr;
		logic [15:0]           dout;
		logic [15:0]           rdata;
		logic                  write;
		logic [`EBU_CFG_W-1:0] cfg;
		logic [4:0]            cs;
		logic                  ale;
		logic                  rd_n;
		logic                  wr_n;
		logic [1:0]            dat_oe_n;
		logic                  done;
		logic                  err;
		logic                  ack_n;
		logic                  want_n;
		logic [2:0]            rdy_s;
		logic [2:0]            hold_s;
		logic [2:0]            ack_s;
		logic                  rdy_n;
		logic                  hold_n;
		logic                  grant_n;
	} ebu_regs_t;
endpackage : ebu_pkg

// [ebu_external_bus_unit.sv]
`timescale 1ns/10ps
// How it works
// - Single-chip or four external data/addressing modes
// - Demux: address port, data port, low byte
// - Multiplexed: address then data on data port
// - Cycle, tristate, strobe length, rw delay programmable
// - Four windows, each select plus config
// - Window four over three, two over one
// - Unmatched addresses use default bus config
// - Five chip selects: four windows plus default
// - Unlatched mode decodes selects straight from address
// - Ready input stretches access until device ready
// - Arbitration enable hands arbitration pins to unit
// - After reset master, hold acknowledge driven
// - Slave direction bit makes acknowledge an input
// - Space 1M/256K/64K drives 4/2/0 segment lines
// - Full space drives all eight segment lines
`include "ebu_cfg.svh"
module ebu_external_bus_unit (
	// Clock and reset
	input  wire logic                           clk_sys_in,
	input  wire logic                           sys_rst_in,
	// CPU access port
	input  wire logic                           req_in,
	input  wire logic [23:0]                    addr_in,
	input  wire logic [15:0]                    wdata_in,
	input  wire logic                           write_in,
	output logic      [15:0]                    rdata_out,
	output logic                                done_out,
	output logic                                err_out,
	// Configuration
	input  wire logic                           single_chip_in,
	input  wire logic [1:0]                     addr_space_in,
	input  wire logic [`EBU_CFG_W-1:0]          default_bus_config_in,
	input  wire logic [3:0][`EBU_CFG_W-1:0]     window_bus_config_in,
	input  wire logic [3:0][15:0]               window_address_select_in,
	input  wire logic                           unlatched_select_cfg_in,
	input  wire logic                           arbitration_enable_in,
	input  wire logic                           slave_mode_direction_bit_in,
	// Status
	output ebu_pkg::ebu_state_t                 state_out,
	// External bus pins
	output logic      [15:0]                    address_port_out,
	output logic      [7:0]                     upper_segment_lines_out,
	output logic                                bus_oe_n_out,
	input  wire logic [15:0]                    data_port_in,
	output logic      [15:0]                    data_port_out,
	output logic      [1:0]                     data_port_oe_n_out,
	output logic                                ale_out,
	output logic                                rd_n_out,
	output logic                                wr_n_out,
	output logic      [4:0]                     cs_n_out,
	input  wire logic                           ready_n_in,
	// Arbitration pins
	input  wire logic                           hold_n_in,
	input  wire logic                           hold_acknowledge_n_in,
	output logic                                hold_acknowledge_n_out,
	output logic                                hold_acknowledge_oe_n_out,
	output logic                                bus_request_out_n_out
);
	import ebu_pkg::*;

	ebu_regs_t s;
	ebu_regs_t next_s;
	logic      arb;
	logic      slave;
	logic      owned;

	// Window match: base compared above the window size
	function automatic logic win_hit(input logic [23:0] a, input logic [15:0] sel);
		logic [11:0] mask;
		mask = 12'hfff << sel[`EBU_SEL_SIZE_HI:0];
		return ((a[23:`EBU_WIN_LSB] ^ sel[`EBU_SEL_BASE_HI:`EBU_SEL_BASE_LO]) & mask) == 12'h000;
	endfunction : win_hit

	// One-hot select: bit 0 default, bits 4..1 windows
	function automatic logic [4:0] pick(input logic [23:0] a);
		logic [4:0] r;
		r = 5'h00;
		r[`EBU_CS_DEFAULT] = 1'b1;
		for (int w = 0; w < 4; w++) begin
			if (window_bus_config_in[w][`EBU_F_WIN_EN] && win_hit(a, window_address_select_in[w])) begin
				r = 5'h00;
				r[w+1] = 1'b1;
			end
		end
		return r;
	endfunction : pick

	function automatic logic [`EBU_CFG_W-1:0] cfg_of(input logic [4:0] cs);
		logic [`EBU_CFG_W-1:0] c;
		c = default_bus_config_in;
		for (int w = 0; w < 4; w++) begin
			if (cs[w+1]) begin
				c = window_bus_config_in[w];
			end
		end
		return c;
	endfunction : cfg_of

	assign arb   = arbitration_enable_in;
	assign slave = arb && slave_mode_direction_bit_in;
	assign owned = !single_chip_in && s.st != ST_HOLD && !(slave && s.grant_n && s.st == ST_IDLE);

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		next_s = s;
		next_s.done = 1'b0;
		next_s.err = 1'b0;
		// Three-stage synchronisers, change taken when stages two and three agree
		next_s.rdy_s  = {s.rdy_s[1:0], ready_n_in};
		next_s.hold_s = {s.hold_s[1:0], hold_n_in};
		next_s.ack_s  = {s.ack_s[1:0], hold_acknowledge_n_in};
		if (s.rdy_s[1] == s.rdy_s[2]) begin
			next_s.rdy_n = s.rdy_s[2];
		end
		if (s.hold_s[1] == s.hold_s[2]) begin
			next_s.hold_n = s.hold_s[2];
		end
		if (s.ack_s[1] == s.ack_s[2]) begin
			next_s.grant_n = s.ack_s[2];
		end
		unique case (s.st)
			ST_IDLE: begin
				next_s.cs = 5'h00;
				if (arb && !slave && !s.hold_n) begin
					// Only entered between accesses, so a running access always completes
					next_s.st = ST_HOLD;
					next_s.ack_n = 1'b0;
					next_s.want_n = !req_in;
				end else if (req_in && !s.done && !s.err) begin
					if (single_chip_in) begin
						next_s.err = 1'b1;
						next_s.done = 1'b1;
					end else if (slave && s.grant_n) begin
						next_s.want_n = 1'b0;
					end else begin
						next_s.addr = addr_in;
						next_s.write = write_in;
						next_s.cs = pick(addr_in);
						next_s.cfg = cfg_of(next_s.cs);
						next_s.ale = 1'b1;
						next_s.cnt = {3'h0, next_s.cfg[`EBU_F_ALE_EXT]};
						if (next_s.cfg[`EBU_F_MUX]) begin
							next_s.dout = addr_in[15:0];
							next_s.dat_oe_n = 2'b00;
						end else begin
							next_s.dout = wdata_in;
							next_s.dat_oe_n = write_in ? {!next_s.cfg[`EBU_F_BUS16], 1'b0} : 2'b11;
						end
						next_s.st = ST_ALE;
					end
				end
			end
			ST_ALE: begin
				if (s.cnt != 4'h0) begin
					next_s.cnt = s.cnt - 4'h1;
				end else begin
					next_s.ale = 1'b0;
					next_s.dout = s.write ? wdata_in : 16'h0000;
					next_s.dat_oe_n = s.write ? {!s.cfg[`EBU_F_BUS16], 1'b0} : 2'b11;
					next_s.cnt = {3'h0, s.cfg[`EBU_F_RW_DLY]};
					next_s.st = ST_RWD;
				end
			end
			ST_RWD: begin
				if (s.cnt != 4'h0) begin
					next_s.cnt = s.cnt - 4'h1;
				end else begin
					next_s.rd_n = s.write;
					next_s.wr_n = !s.write;
					next_s.cnt = s.cfg[`EBU_F_WAIT_HI:`EBU_F_WAIT_LO];
					next_s.st = ST_WAIT;
				end
			end
			ST_WAIT: begin
				if (s.cnt != 4'h0) begin
					next_s.cnt = s.cnt - 4'h1;
				end else if (!(s.cfg[`EBU_F_RDY_EN] && s.rdy_n)) begin
					next_s.rdata = s.cfg[`EBU_F_BUS16] ? data_port_in : {8'h00, data_port_in[7:0]};
					next_s.rd_n = 1'b1;
					next_s.wr_n = 1'b1;
					next_s.done = 1'b1;
					next_s.st = (!s.write && s.cfg[`EBU_F_TRIST]) ? ST_TRIST : ST_END;
				end
			end
			ST_TRIST: begin
				next_s.st = ST_END;
			end
			ST_END: begin
				next_s.cs = 5'h00;
				next_s.dat_oe_n = 2'b11;
				next_s.want_n = 1'b1;
				next_s.st = ST_IDLE;
			end
			ST_HOLD: begin
				next_s.want_n = !req_in;
				if (s.hold_n) begin
					next_s.ack_n = 1'b1;
					next_s.want_n = 1'b1;
					next_s.st = ST_IDLE;
				end
			end
		endcase
		if (sys_rst_in) begin
			next_s = '0;
			next_s.st = ST_IDLE;
			next_s.rd_n = 1'b1;
			next_s.wr_n = 1'b1;
			next_s.dat_oe_n = 2'b11;
			next_s.ack_n = 1'b1;
			next_s.want_n = 1'b1;
			next_s.rdy_s = 3'h7;
			next_s.hold_s = 3'h7;
			next_s.ack_s = 3'h7;
			next_s.rdy_n = 1'b1;
			next_s.hold_n = 1'b1;
			next_s.grant_n = 1'b1;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		s <= next_s;
	end

	////////////////////////////////////////////////////////////////////////
	logic [7:0] seg_mask;
	always_comb begin
		unique case (addr_space_in)
			`EBU_SPACE_64K:  seg_mask = `EBU_SEG_64K;
			`EBU_SPACE_256K: seg_mask = `EBU_SEG_256K;
			`EBU_SPACE_1M:   seg_mask = `EBU_SEG_1M;
			`EBU_SPACE_16M:  seg_mask = `EBU_SEG_16M;
		endcase
	end

	assign rdata_out                 = s.rdata;
	assign done_out                  = s.done;
	assign err_out                   = s.err;
	assign state_out                 = s.st;
	assign address_port_out          = s.cfg[`EBU_F_MUX] ? 16'h0000 : s.addr[15:0];
	assign upper_segment_lines_out   = s.addr[23:16] & seg_mask;
	assign bus_oe_n_out              = !owned;
	assign data_port_out             = s.dout;
	assign data_port_oe_n_out        = owned ? s.dat_oe_n : 2'b11;
	assign ale_out                   = s.ale;
	assign rd_n_out                  = s.rd_n;
	assign wr_n_out                  = s.wr_n;
	// Unlatched selects follow the address while the bus is owned, glitches included
	assign cs_n_out                  = ~((unlatched_select_cfg_in && owned) ? pick(s.addr) : s.cs);
	assign hold_acknowledge_n_out    = s.ack_n;
	assign hold_acknowledge_oe_n_out = slave;
	assign bus_request_out_n_out     = arb ? s.want_n : 1'b1;

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (sys_rst_in);

	a_single_chip: assert property (single_chip_in |-> bus_oe_n_out)
		else $error("bus driven in single-chip mode");
	a_cs_onehot: assert property ($onehot0(~cs_n_out))
		else $error("more than one chip select active");
	a_narrow_lane: assert property ((s.st == ST_WAIT && !s.cfg[`EBU_F_BUS16]) |-> data_port_oe_n_out[1])
		else $error("high byte driven in 8-bit mode");
	a_mux_addr: assert property ((s.st == ST_ALE && s.cfg[`EBU_F_MUX]) |-> data_port_out == s.addr[15:0])
		else $error("address missing on data port");
	a_ready_wait: assert property ((s.st == ST_WAIT && s.cnt == 4'h0 && s.cfg[`EBU_F_RDY_EN] && s.rdy_n)
		|=> s.st == ST_WAIT && !done_out)
		else $error("access ended without ready");
	a_hold_float: assert property (!hold_acknowledge_n_out |-> bus_oe_n_out && $past(s.st) inside {ST_IDLE, ST_HOLD})
		else $error("acknowledge without floating bus");
	a_master_drive: assert property (!slave |-> !hold_acknowledge_oe_n_out
		&& (hold_acknowledge_n_out || s.st == ST_HOLD))
		else $error("master not driving acknowledge");
	a_seg_width: assert property ((addr_space_in == `EBU_SPACE_1M) |-> upper_segment_lines_out[7:4] == 4'h0)
		else $error("segment lines beyond space driven");
	a_done_pulse: assert property (done_out |=> !done_out)
		else $error("done held longer than one cycle");
	a_rw_delay: assert property ((s.st == ST_RWD && s.cnt == 4'h1) |=> s.rd_n && s.wr_n ##1 (!s.rd_n || !s.wr_n))
		else $error("strobe delay wrong");

	c_read: cover property (s.st == ST_WAIT && !s.rd_n ##1 done_out);
	c_write: cover property (s.st == ST_WAIT && !s.wr_n ##1 done_out);
	c_hold: cover property (!hold_acknowledge_n_out ##1 hold_acknowledge_n_out);
	c_ready: cover property (s.st == ST_WAIT && s.cfg[`EBU_F_RDY_EN] && s.rdy_n && s.cnt == 4'h0);
endmodule : ebu_external_bus_unit

// [ebu_mem_model.sv]
`timescale 1ns/10ps
module ebu_mem_model #(
	parameter logic [15:0] DATA = 16'hc3a5
) (
	// Bus side
	input  wire logic        clk_sys_in,
	input  wire logic        rd_n_in,
	input  wire logic        wr_n_in,
	input  wire logic        slow_in,
	output logic      [15:0] data_out,
	output logic             ready_n_out
);
	logic [3:0] busy = 4'h0;
	// Released bus shows inverted data so a stale copy never passes
	assign data_out    = rd_n_in ? ~DATA : DATA;
	// Slow part withholds ready for four cycles of every strobe
	assign ready_n_out = slow_in && (busy < 4'h4);
	always_ff @(posedge clk_sys_in) begin
		busy <= (rd_n_in && wr_n_in) ? 4'h0 : busy + 4'h1;
	end
endmodule : ebu_mem_model

// [tb_external_bus_controller.sv]
`timescale 1ns/10ps
module tb_external_bus_controller;
	import ebu_pkg::*;
	logic clk_sys_in, sys_rst_in, req_in, write_in, done_out, err_out, single_chip_in, slow;
	logic unlatched_select_cfg_in, arbitration_enable_in, slave_mode_direction_bit_in;
	logic bus_oe_n_out, ale_out, rd_n_out, wr_n_out, ready_n_in, hold_n_in;
	logic hold_acknowledge_n_in, hold_acknowledge_n_out, hold_acknowledge_oe_n_out;
	logic bus_request_out_n_out;
	logic [23:0] addr_in;
	logic [15:0] wdata_in, rdata_out, address_port_out, data_port_in, data_port_out, ap_seen, dp_seen;
	logic [1:0] addr_space_in, data_port_oe_n_out, oe_seen, wo_seen;
	logic [15:0] wd_seen;
	logic [10:0] default_bus_config_in;
	logic [3:0][10:0] window_bus_config_in;
	logic [3:0][15:0] window_address_select_in;
	logic [7:0] upper_segment_lines_out, seg_seen;
	logic [4:0] cs_n_out, cs_seen;
	logic err_seen;
	ebu_state_t state_out, st_seen;
	int n_errors = 0;
	int n_checks = 0;
	ebu_external_bus_unit dut_u (.clk_sys_in, .sys_rst_in, .req_in, .addr_in, .wdata_in,
		.write_in, .rdata_out, .done_out, .err_out, .single_chip_in, .addr_space_in,
		.default_bus_config_in, .window_bus_config_in, .window_address_select_in,
		.unlatched_select_cfg_in, .arbitration_enable_in, .slave_mode_direction_bit_in,
		.state_out, .address_port_out, .upper_segment_lines_out, .bus_oe_n_out,
		.data_port_in, .data_port_out, .data_port_oe_n_out, .ale_out, .rd_n_out, .wr_n_out,
		.cs_n_out, .ready_n_in, .hold_n_in, .hold_acknowledge_n_in, .hold_acknowledge_n_out,
		.hold_acknowledge_oe_n_out, .bus_request_out_n_out);
	ebu_mem_model mem_u (.clk_sys_in, .rd_n_in(rd_n_out), .wr_n_in(wr_n_out), .slow_in(slow),
		.data_out(data_port_in), .ready_n_out(ready_n_in));
	////////////////////////////////////////////////////////////////////////////////
	task chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task wrap_up;
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : wrap_up
	// One access; selects, address and segment values captured while the address strobe is high, write data while the write strobe is low
	task automatic acc(input logic [23:0] a, input logic w, output int cyc);
		cyc = 0;
		wd_seen = 16'h0000;
		wo_seen = 2'h3;
		@(posedge clk_sys_in);
		addr_in <= a;
		write_in <= w;
		wdata_in <= 16'h5a3c;
		req_in <= 1'b1;
		do begin
			@(posedge clk_sys_in);
			#1;
			cyc++;
			if (ale_out === 1'b1) begin
				cs_seen = cs_n_out;
				ap_seen = address_port_out;
				dp_seen = data_port_out;
				oe_seen = data_port_oe_n_out;
				seg_seen = upper_segment_lines_out;
			end
			if (wr_n_out === 1'b0) begin
				wd_seen = data_port_out;
				wo_seen = data_port_oe_n_out;
			end
		end while (done_out !== 1'b1 && cyc < 200);
		err_seen = err_out;
		st_seen = state_out;
		chk("done", done_out, 1'b1);
		@(posedge clk_sys_in);
		req_in <= 1'b0;
		repeat (2) @(posedge clk_sys_in);
	endtask : acc
	////////////////////////////////////////////////////////////////////////////////
	task t_demux;
		int n0, n1;
		acc(24'h301234, 1'b0, n0);
		chk("rdata16", rdata_out, 16'hc3a5);
		chk("addr_port", ap_seen, 16'h1234);
		default_bus_config_in <= 11'h000;
		acc(24'h301234, 1'b0, n1);
		chk("rdata8", rdata_out, 16'h00a5);
		default_bus_config_in <= 11'h203;
		acc(24'h301234, 1'b0, n1);
		chk("wait_states", n1, n0 + 3);
		default_bus_config_in <= 11'h280;
		slow <= 1'b1;
		// Let the synchronised ready settle before the access
		repeat (3) @(posedge clk_sys_in);
		acc(24'h301234, 1'b0, n1);
		chk("ready_stretch", n1 > n0, 1'b1);
		chk("rdata_slow", rdata_out, 16'hc3a5);
		slow <= 1'b0;
		default_bus_config_in <= 11'h300;
		acc(24'h30abcd, 1'b1, n1);
		chk("mux_addr", dp_seen, 16'habcd);
		chk("mux_oe", oe_seen, 2'h0);
		chk("mux_wdata", wd_seen, 16'h5a3c);
		default_bus_config_in <= 11'h000;
		acc(24'h301234, 1'b1, n1);
		chk("lane8", wo_seen, 2'h2);
		chk("wdata8", wd_seen[7:0], 8'h3c);
		default_bus_config_in <= 11'h270;
		acc(24'h301234, 1'b0, n1);
		chk("timing", n1, n0 + 2);
		chk("tristate", st_seen == ST_TRIST, 1'b1);
		chk("rdata_timed", rdata_out, 16'hc3a5);
		default_bus_config_in <= 11'h200;
		single_chip_in <= 1'b1;
		acc(24'h301234, 1'b0, n1);
		chk("refused", err_seen, 1'b1);
		single_chip_in <= 1'b0;
	endtask : t_demux
	task t_windows;
		logic [23:0] ads [6] = '{24'h100010, 24'h108000, 24'h200010, 24'h208000, 24'h300000, 24'h100010};
		logic [4:0] exp [6] = '{5'h1b, 5'h1d, 5'h0f, 5'h17, 5'h1e, 5'h1b};
		int n;
		for (int i = 0; i < 6; i++) begin
			unlatched_select_cfg_in <= (i == 5);
			acc(ads[i], 1'b0, n);
			chk("cs_n", cs_seen, exp[i]);
			#1;
			chk("cs_idle", cs_n_out, (i == 5) ? exp[i] : 5'h1f);
			@(posedge clk_sys_in);
		end
		unlatched_select_cfg_in <= 1'b0;
	endtask : t_windows
	task t_segments;
		logic [7:0] mask [4] = '{8'h00, 8'h03, 8'h0f, 8'hff};
		int n;
		for (int s = 0; s < 4; s++) begin
			addr_space_in <= s[1:0];
			acc(24'hab1234, 1'b0, n);
			chk("segment", seg_seen, 8'hab & mask[s]);
		end
	endtask : t_segments
	task t_hold;
		int k;
		arbitration_enable_in <= 1'b1;
		// Hold raised mid-access: the access must still complete first
		fork
			acc(24'h301234, 1'b0, k);
			begin
				repeat (2) @(posedge clk_sys_in);
				hold_n_in <= 1'b0;
			end
		join
		#1;
		k = 0;
		while (hold_acknowledge_n_out !== 1'b0 && k < 50) begin
			@(posedge clk_sys_in);
			#1;
			k++;
		end
		chk("ack", hold_acknowledge_n_out, 1'b0);
		chk("bus_float", bus_oe_n_out, 1'b1);
		chk("ack_oe", hold_acknowledge_oe_n_out, 1'b0);
		chk("busreq_hold", bus_request_out_n_out, 1'b1);
		@(posedge clk_sys_in);
		hold_n_in <= 1'b1;
		repeat (8) @(posedge clk_sys_in);
		#1;
		chk("ack_off", hold_acknowledge_n_out, 1'b1);
		@(posedge clk_sys_in);
		slave_mode_direction_bit_in <= 1'b1;
		repeat (4) @(posedge clk_sys_in);
		// Slave waits for the grant before touching the bus
		fork
			acc(24'h301234, 1'b0, k);
			begin
				repeat (4) @(posedge clk_sys_in);
				#1;
				chk("slave_oe", hold_acknowledge_oe_n_out, 1'b1);
				chk("slave_busreq", bus_request_out_n_out, 1'b0);
				chk("slave_float", bus_oe_n_out, 1'b1);
				@(posedge clk_sys_in);
				hold_acknowledge_n_in <= 1'b0;
			end
		join
		#1;
		chk("slave_busreq_off", bus_request_out_n_out, 1'b1);
		@(posedge clk_sys_in);
		hold_acknowledge_n_in <= 1'b1;
		slave_mode_direction_bit_in <= 1'b0;
		arbitration_enable_in <= 1'b0;
	endtask : t_hold
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		clk_sys_in = 1'b0;
		forever #5 clk_sys_in = ~clk_sys_in;
	end
	initial begin
		repeat (5000) @(posedge clk_sys_in);
		n_errors++;
		wrap_up();
	end
	initial begin
		{req_in, write_in, single_chip_in, slow, unlatched_select_cfg_in} = '0;
		{arbitration_enable_in, slave_mode_direction_bit_in} = '0;
		{hold_n_in, hold_acknowledge_n_in} = 2'h3;
		addr_in = '0;
		wdata_in = '0;
		addr_space_in = 2'h3;
		default_bus_config_in = 11'h200;
		window_bus_config_in = {4{11'h600}};
		window_address_select_in = {16'h2000, 16'h2004, 16'h1000, 16'h1004};
		sys_rst_in = 1'b1;
		repeat (20) @(posedge clk_sys_in);
		sys_rst_in <= 1'b0;
		@(posedge clk_sys_in);
		#1;
		chk("rst_cs", cs_n_out, 5'h1f);
		chk("rst_strobes", {rd_n_out, wr_n_out, ale_out}, 3'h6);
		t_demux();
		t_windows();
		t_segments();
		t_hold();
		wrap_up();
	end
endmodule : tb_external_bus_controller
